// file: rtl/eepg_slave.sv
// eepg_slave: two-wire serial slave for a 256 x 8 nonvolatile array
// assumes: scl and sda come from pins; sda is open drain, resolved outside
`timescale 1ns/1ps
module eepg_slave #(
  parameter int WR_CYCLES = eepg_pkg::WR_CYCLES,
  parameter logic [3:0] DEV_TYPE = 4'h5 // arbitrary type code
) (
  // system side
  input wire logic ref_clk,
  input wire logic resetn,
  // link sampling clock
  input wire logic linkClk,
  // serial pins
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // status
  output logic wrBusy
);
  localparam int CW = $clog2(WR_CYCLES + 1);
  localparam logic [3:0] FILT = 4'(eepg_pkg::FILT_CYCLES);
  localparam logic [CW-1:0] WR_LAST = CW'(WR_CYCLES - 1);

  typedef struct packed {
    eepg_pkg::eepg_state_t st;
    logic sclR;
    logic sdaR;
    logic [3:0] fCntC;
    logic [3:0] fCntD;
    logic sclF;
    logic sdaF;
    logic sclP;
    logic sdaP;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [3:0] cnt;
    logic [7:0] addr;
    logic [15:0] vld;
    logic [3:0] idx;
    logic oe;
    logic req;
  } eepg_link_t;

  typedef struct packed {
    logic reqP;
    logic busy;
    logic [CW-1:0] cnt;
  } eepg_ref_t;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0] mem [eepg_pkg::DEPTH];
  logic [7:0] pg [eepg_pkg::PAGE_BYTES];
  logic memWe;
  logic [7:0] memWa;
  logic pgWe;
  logic [3:0] pgWa;
  eepg_link_t lq, ld;
  eepg_ref_t rq, rd;
  logic lnkRs1, lnkRstN;
  logic sclS1, sclS2, sdaS1, sdaS2;
  logic busyS1, busyS2;
  logic reqS1, reqS2;
  logic rise, fall, start, stop, quiet;

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  // reset and pins into the link domain
  always_ff @(posedge linkClk) begin
    lnkRs1 <= resetn;
    lnkRstN <= lnkRs1;
    sclS1 <= scl;
    sclS2 <= sclS1;
    sdaS1 <= sdaIn;
    sdaS2 <= sdaS1;
    busyS1 <= rq.busy;
    busyS2 <= busyS1;
  end

  // write request toggle into the system domain
  always_ff @(posedge ref_clk) begin
    reqS1 <= lq.req;
    reqS2 <= reqS1;
  end

  // ----------------------------------------
  // write cycle timer (system domain)
  // ----------------------------------------
  // busy for the whole nonvolatile write time
  always_comb begin
    rd = rq;
    rd.reqP = reqS2;
    if (rq.busy) begin
      rd.cnt = rq.cnt + CW'(1);
      if (rq.cnt == WR_LAST) begin
        rd.busy = 1'b0;
        rd.cnt = '0;
      end
    end else if (reqS2 != rq.reqP) begin
      rd.busy = 1'b1;
      rd.cnt = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rq <= '0;
    end else begin
      rq <= rd;
    end
  end

  // ----------------------------------------
  // line conditions (link domain)
  // ----------------------------------------
  assign rise = lq.sclF & ~lq.sclP;
  assign fall = ~lq.sclF & lq.sclP;
  assign start = lq.sclF & lq.sclP & lq.sdaP & ~lq.sdaF;
  assign stop = lq.sclF & lq.sclP & ~lq.sdaP & lq.sdaF;
  assign quiet = (lq.st == eepg_pkg::ST_COMMIT) || (lq.st == eepg_pkg::ST_WAITHI) ||
                 (lq.st == eepg_pkg::ST_WAITLO);

  // ----------------------------------------
  // protocol engine
  // ----------------------------------------
  always_comb begin
    ld = lq;
    memWe = 1'b0;
    memWa = {lq.addr[7:4], lq.idx};
    pgWe = 1'b0;
    pgWa = lq.addr[3:0];
    // spike filter: level taken after stable samples
    ld.sclR = sclS2;
    ld.sdaR = sdaS2;
    ld.fCntC = (sclS2 != lq.sclR) ? 4'h0 : ((lq.fCntC == FILT) ? FILT : lq.fCntC + 4'h1);
    ld.fCntD = (sdaS2 != lq.sdaR) ? 4'h0 : ((lq.fCntD == FILT) ? FILT : lq.fCntD + 4'h1);
    if (lq.fCntC == FILT) begin
      ld.sclF = lq.sclR;
    end
    if (lq.fCntD == FILT) begin
      ld.sdaF = lq.sdaR;
    end
    ld.sclP = lq.sclF;
    ld.sdaP = lq.sdaF;
    if (!quiet && start) begin
      ld.st = eepg_pkg::ST_DEVADR;
      ld.cnt = 4'h0;
      ld.oe = 1'b0;
    end else if (!quiet && stop) begin
      ld.oe = 1'b0;
      ld.idx = 4'h0;
      ld.st = (|lq.vld) ? eepg_pkg::ST_COMMIT : eepg_pkg::ST_IDLE;
    end else begin
      case (lq.st)
        eepg_pkg::ST_DEVADR, eepg_pkg::ST_WADR, eepg_pkg::ST_WDATA: begin
          if (rise) begin
            ld.sh = {lq.sh[6:0], lq.sdaF};
            ld.cnt = lq.cnt + 4'h1;
          end else if (fall && lq.cnt == 4'h8) begin
            ld.cnt = 4'h0;
            ld.oe = 1'b1;
            if (lq.st == eepg_pkg::ST_DEVADR) begin
              // type code only; three bits below are don't care
              ld.st = (lq.sh[7:4] == DEV_TYPE) ? eepg_pkg::ST_DEVACK : eepg_pkg::ST_IDLE;
              ld.oe = (lq.sh[7:4] == DEV_TYPE);
            end else if (lq.st == eepg_pkg::ST_WADR) begin
              ld.addr = lq.sh;
              ld.st = eepg_pkg::ST_WADRACK;
            end else begin
              pgWe = 1'b1;
              ld.vld[lq.addr[3:0]] = 1'b1;
              ld.addr = {lq.addr[7:4], lq.addr[3:0] + 4'h1};
              ld.st = eepg_pkg::ST_WDACK;
            end
          end
        end
        eepg_pkg::ST_DEVACK: begin
          if (fall) begin
            if (lq.sh[0]) begin
              // read: first bit out right away
              ld.tx = mem[lq.addr];
              ld.oe = ~mem[lq.addr][7];
              ld.st = eepg_pkg::ST_RDATA;
            end else begin
              ld.oe = 1'b0;
              ld.st = eepg_pkg::ST_WADR;
            end
          end
        end
        eepg_pkg::ST_WADRACK, eepg_pkg::ST_WDACK: begin
          if (fall) begin
            ld.oe = 1'b0;
            ld.st = eepg_pkg::ST_WDATA;
          end
        end
        eepg_pkg::ST_RDATA: begin
          if (fall) begin
            ld.cnt = lq.cnt + 4'h1;
            ld.tx = {lq.tx[6:0], 1'b0};
            ld.oe = ~lq.tx[6];
            if (lq.cnt == 4'h7) begin
              ld.cnt = 4'h0;
              ld.oe = 1'b0;
              ld.st = eepg_pkg::ST_RACK;
            end
          end
        end
        eepg_pkg::ST_RACK: begin
          if (rise) begin
            ld.addr = lq.addr + 8'h01;
            ld.cnt = lq.sdaF ? 4'h0 : 4'h1;
            if (lq.sdaF) begin
              ld.st = eepg_pkg::ST_IDLE;
            end
          end else if (fall && lq.cnt == 4'h1) begin
            ld.cnt = 4'h0;
            ld.tx = mem[lq.addr];
            ld.oe = ~mem[lq.addr][7];
            ld.st = eepg_pkg::ST_RDATA;
          end
        end
        eepg_pkg::ST_COMMIT: begin
          // one page slot per cycle into the array
          memWe = lq.vld[lq.idx];
          ld.idx = lq.idx + 4'h1;
          if (lq.idx == 4'hF) begin
            ld.vld = '0;
            ld.req = ~lq.req;
            ld.st = eepg_pkg::ST_WAITHI;
          end
        end
        eepg_pkg::ST_WAITHI: begin
          if (busyS2) begin
            ld.st = eepg_pkg::ST_WAITLO;
          end
        end
        eepg_pkg::ST_WAITLO: begin
          if (!busyS2) begin
            ld.st = eepg_pkg::ST_IDLE;
          end
        end
        default: begin
          ld.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge linkClk) begin
    if (!lnkRstN) begin
      lq <= '0;
      lq.sclF <= 1'b1;
      lq.sdaF <= 1'b1;
      lq.sclP <= 1'b1;
      lq.sdaP <= 1'b1;
      lq.sclR <= 1'b1;
      lq.sdaR <= 1'b1;
    end else begin
      lq <= ld;
    end
  end

  // page buffer and array, no reset
  always_ff @(posedge linkClk) begin
    if (pgWe) begin
      pg[pgWa] <= lq.sh;
    end
    if (memWe) begin
      mem[memWa] <= pg[lq.idx];
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOe = lq.oe;
  assign wrBusy = rq.busy;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_quiet;
    @(posedge linkClk) disable iff (!lnkRstN) quiet |-> !lq.oe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("sda driven during write");

  property p_nostart;
    @(posedge linkClk) disable iff (!lnkRstN) (quiet && start) |=>
      lq.st != eepg_pkg::ST_DEVADR;
  endproperty
  a_nostart: assert property (p_nostart) else $error("start taken while busy");

  property p_pageinc;
    @(posedge linkClk) disable iff (!lnkRstN) (pgWe && !start && !stop) |=>
      lq.addr[7:4] == $past(lq.addr[7:4]) && lq.addr[3:0] == $past(lq.addr[3:0]) + 4'h1;
  endproperty
  a_pageinc: assert property (p_pageinc) else $error("page address step wrong");

  property p_rdinc;
    @(posedge linkClk) disable iff (!lnkRstN)
      (lq.st == eepg_pkg::ST_RACK && rise && !start && !stop) |=> lq.addr == $past(lq.addr) + 8'h01;
  endproperty
  a_rdinc: assert property (p_rdinc) else $error("read address not advanced");

  property p_dataack;
    @(posedge linkClk) disable iff (!lnkRstN) pgWe |=> lq.oe && lq.st == eepg_pkg::ST_WDACK;
  endproperty
  a_dataack: assert property (p_dataack) else $error("data byte not acknowledged");

  property p_release;
    @(posedge linkClk) disable iff (!lnkRstN)
      (lq.st == eepg_pkg::ST_RDATA && fall && lq.cnt == 4'h7 && !start && !stop) |=>
      !lq.oe && lq.st == eepg_pkg::ST_RACK;
  endproperty
  a_release: assert property (p_release) else $error("sda not released for ack");

  property p_nowrite;
    @(posedge linkClk) disable iff (!lnkRstN) (stop && !quiet && lq.vld == 16'h0000) |=>
      lq.st == eepg_pkg::ST_IDLE ##1 !busyS2 [*2];
  endproperty
  a_nowrite: assert property (p_nowrite) else $error("write started without data");

  property p_badtype;
    @(posedge linkClk) disable iff (!lnkRstN)
      (lq.st == eepg_pkg::ST_DEVADR && fall && lq.cnt == 4'h8 && lq.sh[7:4] != DEV_TYPE && !start && !stop)
      |=> !lq.oe;
  endproperty
  a_badtype: assert property (p_badtype) else $error("foreign address acknowledged");

  property p_wrlen;
    @(posedge ref_clk) disable iff (!resetn) $fell(rq.busy) |-> $past(rq.cnt) == WR_LAST;
  endproperty
  a_wrlen: assert property (p_wrlen) else $error("write cycle length wrong");

endmodule // eepg_slave

// file: rtl/eepg_pkg.sv
// eepg_pkg: constants for the two-wire page-write memory slave
// assumes: ref_clk at 100 MHz, link sampling clock of 125 ns period
package eepg_pkg;
  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int PAGE_W = 4;
  localparam int DEPTH = 256;
  localparam int PAGE_BYTES = 16;
  localparam int BYTE_BITS = 8;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int REF_MHZ = 100;
  localparam int LINK_PERIOD_NS = 125;
  localparam int T_WR_MS = 10;
  localparam int T_SPIKE_NS = 100;
  // longest write time rounds down
  localparam int WR_CYCLES = T_WR_MS * 1000 * REF_MHZ;
  // least filter time rounds up, at least one sample
  localparam int FILT_RAW = (T_SPIKE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int FILT_CYCLES = (FILT_RAW < 1) ? 1 : FILT_RAW;
  // ----------------------------------------
  // protocol states
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_DEVADR, ST_DEVACK, ST_WADR, ST_WADRACK,
    ST_WDATA, ST_WDACK, ST_RDATA, ST_RACK,
    ST_COMMIT, ST_WAITHI, ST_WAITLO
  } eepg_state_t;
endpackage

// file: verif/eepg_master_model.sv
// eepg_master_model: behavioural two-wire bus master for the memory slave
// assumes: sda is the resolved wire with a pull-up; scl is driven only here
`timescale 1ns/1ps
module eepg_master_model (
  // serial pins
  output logic scl,
  output logic sdaPull,
  input wire logic sda
);
  // ----------------------------------------
  // bus timing, slow enough for the slave's filters
  // ----------------------------------------
  localparam int T_LO = 1500;
  localparam int T_HI = 800;
  localparam int T_SET = 750;
  // bus idles released and high
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  // one clock pulse; data set mid-low, sampled at end of high; optional short spike
  task automatic bitOut(input logic b, input logic spike, output logic smp);
    #T_SET;
    sdaPull = ~b;
    #(T_LO - T_SET);
    scl = 1'b1;
    if (spike) begin
      #300;
      scl = 1'b0;
      #60;
      scl = 1'b1;
      #(T_HI - 360);
    end else begin
      #T_HI;
    end
    smp = sda;
    scl = 1'b0;
  endtask
  // start or repeated start
  task automatic start();
    if (scl == 1'b0) begin
      #T_SET;
      sdaPull = 1'b0;
      #(T_LO - T_SET);
      scl = 1'b1;
    end
    #T_HI;
    sdaPull = 1'b1;
    #T_HI;
    scl = 1'b0;
  endtask
  // stop, then bus free time
  task automatic stop();
    #T_SET;
    sdaPull = 1'b1;
    #(T_LO - T_SET);
    scl = 1'b1;
    #T_HI;
    sdaPull = 1'b0;
    #(2 * T_HI);
  endtask
  // byte out msb first, ack in ninth pulse
  task automatic wrByte(input logic [7:0] d, input int spikeBit, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitOut(d[i], i == spikeBit, s);
    end
    bitOut(1'b1, 1'b0, s);
    ack = ~s;
  endtask
  // byte in, then master ack or nack
  task automatic rdByte(input logic mAck, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitOut(1'b1, 1'b0, d[i]);
    end
    bitOut(~mAck, 1'b0, s);
  endtask
endmodule // eepg_master_model

// file: verif/eepg_slave_tb_top.sv
// eepg_slave_tb_top: self-checking bench for the two-wire memory slave
// assumes: master model drives the bus; slave filters sample on linkClk
`timescale 1ns/1ps
module eepg_slave_tb_top;
  localparam logic [3:0] DEV = 4'h6; // arbitrary type code
  localparam int WRC = 5000;
  logic ref_clk = 1'b0;
  logic linkClk = 1'b0;
  logic resetn = 1'b0;
  logic scl, sdaPull, sdaOut, sdaOe, wrBusy, ack;
  wire logic sda = (sdaPull || (sdaOe && !sdaOut)) ? 1'b0 : 1'b1;
  logic [7:0] expMem [256];
  logic [7:0] d;
  logic [3:0] lo;
  int err_total = 0;
  int comparisons = 0;
  int busyCnt = 0;
  // ----------------------------------------
  // clocks and units
  // ----------------------------------------
  always #5 ref_clk = ~ref_clk;
  initial begin
    #17;
    forever #62.5 linkClk = ~linkClk;
  end
  always @(negedge ref_clk) if (wrBusy === 1'b1) busyCnt++;
  eepg_slave #(.WR_CYCLES(WRC), .DEV_TYPE(DEV)) u_eepg_slave (.ref_clk(ref_clk), .resetn(resetn),
    .linkClk(linkClk), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .wrBusy(wrBusy));
  eepg_master_model u_eepg_master_model (.scl(scl), .sdaPull(sdaPull), .sda(sda));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // slave address with random don't-care bits
  function automatic logic [7:0] devAdr(input logic rd);
    return {DEV, 3'($urandom), rd};
  endfunction
  task automatic addr(input logic rd, input logic expAck);
    u_eepg_master_model.start();
    u_eepg_master_model.wrByte(devAdr(rd), -1, ack);
    chk(16'(ack), 16'(expAck), "address ack");
  endtask
  task automatic waitIdle();
    repeat (500) @(negedge ref_clk);
    for (int n = 0; n < 20000 && wrBusy !== 1'b0; n++) @(negedge ref_clk);
  endtask
  task automatic summarize();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    #1000000;
    err_total++;
    summarize();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(44));
    repeat (16) @(negedge ref_clk);
    resetn = 1'b1;
    #2000;
    // page write from top of page, seventeen bytes, spike on one clock
    addr(1'b0, 1'b1);
    u_eepg_master_model.wrByte(8'hFF, -1, ack);
    for (int k = 0; k < 17; k++) begin
      d = 8'($urandom);
      u_eepg_master_model.wrByte(d, (k == 3) ? 2 : -1, ack);
      chk(16'(ack), 16'h0001, "data ack");
      lo = 4'(15 + k);
      expMem[{4'hF, lo}] = d;
    end
    busyCnt = 0;
    u_eepg_master_model.stop();
    // poll while busy, then after
    addr(1'b0, 1'b0);
    u_eepg_master_model.stop();
    waitIdle();
    chk(16'(busyCnt), 16'(WRC), "write cycle length");
    addr(1'b0, 1'b1);
    u_eepg_master_model.stop();
    #6000;
    chk(16'(busyCnt), 16'(WRC), "no write after address only");
    // stop after word address only
    addr(1'b0, 1'b1);
    u_eepg_master_model.wrByte(8'h40, -1, ack);
    chk(16'(ack), 16'h0001, "word address ack");
    u_eepg_master_model.stop();
    #6000;
    chk(16'(busyCnt), 16'(WRC), "no write after word address only");
    // byte write at zero
    addr(1'b0, 1'b1);
    u_eepg_master_model.wrByte(8'h00, -1, ack);
    d = 8'($urandom);
    u_eepg_master_model.wrByte(d, -1, ack);
    expMem[0] = d;
    u_eepg_master_model.stop();
    waitIdle();
    // random sequential read of FE and FF, the last two bytes of the page
    addr(1'b0, 1'b1);
    u_eepg_master_model.wrByte(8'hFE, -1, ack);
    addr(1'b1, 1'b1);
    chk(16'(wrBusy), 16'h0000, "dummy write busy");
    u_eepg_master_model.rdByte(1'b1, d);
    chk(16'(d), 16'(expMem[8'hFE]), "read FE");
    u_eepg_master_model.rdByte(1'b0, d);
    chk(16'(d), 16'(expMem[8'hFF]), "read FF");
    u_eepg_master_model.stop();
    chk(16'(sdaOe), 16'h0000, "released after stop");
    // current address single read wraps to zero
    addr(1'b1, 1'b1);
    u_eepg_master_model.rdByte(1'b0, d);
    chk(16'(d), 16'(expMem[0]), "current read");
    u_eepg_master_model.stop();
    // foreign type code is ignored
    u_eepg_master_model.start();
    u_eepg_master_model.wrByte({~DEV, 4'h0}, -1, ack);
    chk(16'(ack), 16'h0000, "foreign address");
    u_eepg_master_model.stop();
    summarize();
  end
endmodule // eepg_slave_tb_top
